// ==== hw/multi_io_flash_read.sv ====
`timescale 1ns/1ps
`default_nettype none
module multi_io_flash_read
   import flash_read_pkg::*;
(
   // Clock, reset, enable
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic enable_i,
   // Serial link pins
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic [3:0] io_i,
   output logic [3:0] io_o,
   output logic [3:0] io_oe_n_o,
   // Configuration bits
   input wire logic addr_long_i,
   input wire logic quad_enable_i,
   input wire logic quad_instruction_mode_i,
   input wire logic [3:0] latency_code_i,
   // Memory read port
   output logic mem_req_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   input wire logic mem_ready_i,
   input wire logic mem_valid_i,
   input wire logic [7:0] mem_data_i,
   // Status
   output logic execute_in_place_o,
   output logic busy_o,
   output logic underrun_o
);
   typedef enum logic [6:0] {
      ST_IDLE = 7'b000_0001,
      ST_INSTR = 7'b000_0010,
      ST_ADDR = 7'b000_0100,
      ST_MODE = 7'b000_1000,
      ST_DUMMY = 7'b001_0000,
      ST_DATA = 7'b010_0000,
      ST_IGNORE = 7'b100_0000
   } state_e;

   state_e state_q;
   logic sck_s;
   logic cs_n_s;
   logic cs_sel_s;
   logic [3:0] io_s;
   logic sck_prev_q;
   logic cs_prev_q;
   logic rise;
   logic fall;
   logic cs_rise;
   logic cs_fall;
   logic quad_q;
   logic cont_q;
   logic cont_next_q;
   logic [5:0] bits_q;
   logic [5:0] addr_bits_q;
   logic [7:0] instr_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0] mode_q;
   logic [3:0] mode_cnt_q;
   logic [3:0] dummy_q;
   logic [7:0] shift_q;
   logic [2:0] out_cnt_q;
   logic start_data;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic fifo_pop;
   logic fifo_flush;
   logic req_q;
   logic [4:0] ahead_q;
   logic [3:0] step;
   logic [2:0] nib_last;

   // Link pins cross into the local clock
   pin_sync #(.WIDTH(6)) u_sync (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .enable_i(enable_i),
      .async_i({sck_i, ~cs_n_i, io_i}),
      .sync_o({sck_s, cs_sel_s, io_s})
   );
   assign cs_n_s = !cs_sel_s; // Inverted so reset reads as deselected

   // Edge detection on synchronised copies
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else if (enable_i) begin
         sck_prev_q <= sck_s;
         cs_prev_q <= cs_n_s;
      end
   end
   assign rise = sck_s && !sck_prev_q && !cs_n_s;
   assign fall = !sck_s && sck_prev_q && !cs_n_s;
   assign cs_rise = cs_n_s && !cs_prev_q;
   assign cs_fall = !cs_n_s && cs_prev_q;

   // Bits per clock and output slot
   assign step = quad_q ? 4'h4 : 4'h2;
   assign nib_last = quad_q ? 3'h1 : 3'h3;

   // Command state machine
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         quad_q <= 1'b0;
         bits_q <= '0;
         addr_bits_q <= '0;
         instr_q <= '0;
         addr_q <= ADDR_RESET;
         mode_q <= '0;
         mode_cnt_q <= '0;
         dummy_q <= '0;
      end else if (enable_i) begin
         if (cs_n_s) begin
            state_q <= ST_IDLE;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  if (cs_fall) begin
                     bits_q <= '0;
                     addr_q <= ADDR_RESET;
                     if (cont_q) begin
                        state_q <= ST_ADDR;
                     end else begin
                        instr_q <= '0;
                        state_q <= ST_INSTR;
                     end
                  end
               end
               ST_INSTR: begin
                  if (rise) begin
                     if (quad_instruction_mode_i) begin
                        instr_q <= {instr_q[3:0], io_s};
                     end else begin
                        instr_q <= {instr_q[6:0], io_s[0]};
                     end
                  end
                  if (rise && (bits_q == (quad_instruction_mode_i ?
                        6'd1 : 6'd7))) begin
                     bits_q <= '0;
                     state_q <= ST_IGNORE;
                     case (quad_instruction_mode_i ? {instr_q[3:0], io_s}
                           : {instr_q[6:0], io_s[0]})
                        DUAL_READ_OP: begin
                           quad_q <= 1'b0;
                           addr_bits_q <= addr_long_i ? 6'd32 : 6'd24;
                           state_q <= ST_ADDR;
                        end
                        DUAL_READ_LONG_OP: begin
                           quad_q <= 1'b0;
                           addr_bits_q <= 6'd32;
                           state_q <= ST_ADDR;
                        end
                        QUAD_READ_OP: begin
                           quad_q <= 1'b1;
                           addr_bits_q <= addr_long_i ? 6'd32 : 6'd24;
                           if (quad_enable_i) state_q <= ST_ADDR;
                        end
                        QUAD_READ_LONG_OP: begin
                           quad_q <= 1'b1;
                           addr_bits_q <= 6'd32;
                           if (quad_enable_i) state_q <= ST_ADDR;
                        end
                        default: state_q <= ST_IGNORE;
                     endcase
                  end else if (rise) begin
                     bits_q <= bits_q + 6'd1;
                  end
               end
               ST_ADDR: begin
                  if (rise) begin
                     if (quad_q) begin
                        addr_q <= {addr_q[ADDR_W-5:0], io_s};
                     end else begin
                        addr_q <= {addr_q[ADDR_W-3:0], io_s[1:0]};
                     end
                     if (bits_q + {2'b00, step} >= addr_bits_q) begin
                        bits_q <= '0;
                        mode_cnt_q <= '0;
                        state_q <= ST_MODE;
                     end else begin
                        bits_q <= bits_q + {2'b00, step};
                     end
                  end
               end
               ST_MODE: begin
                  if (rise) begin
                     if (quad_q) begin
                        mode_q <= {mode_q[3:0], io_s};
                     end else begin
                        mode_q <= {mode_q[5:0], io_s[1:0]};
                     end
                     mode_cnt_q <= mode_cnt_q + 4'h1;
                  end
                  // Mode cycles end on falling edge after last rise
                  if (fall && mode_cnt_q == (quad_q ? QUAD_MODE_CYCLES
                        : DUAL_MODE_CYCLES)) begin
                     dummy_q <= latency_code_i;
                     state_q <= (latency_code_i == 4'h0) ? ST_DATA
                        : ST_DUMMY;
                  end
               end
               ST_DUMMY: begin
                  // Lines are ignored here
                  if (fall) begin
                     if (dummy_q == 4'h1) state_q <= ST_DATA;
                     dummy_q <= dummy_q - 4'h1;
                  end
               end
               ST_DATA: state_q <= ST_DATA;
               ST_IGNORE: state_q <= ST_IGNORE;
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Continuous mode tracking, decided at chip select rise, or cleared at once by the mode reset instruction when sent one bit per clock
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         cont_q <= 1'b0;
         cont_next_q <= 1'b0;
      end else if (enable_i) begin
         if (state_q == ST_MODE && fall) begin
            cont_next_q <= (mode_q[7:4] == CONT_MODE_NIBBLE);
         end
         if (state_q == ST_INSTR && rise && !quad_instruction_mode_i
               && bits_q == 6'd7 && {instr_q[6:0], io_s[0]}
               == MODE_RESET_OP) begin
            cont_q <= 1'b0;
            cont_next_q <= 1'b0;
         end else if (cs_rise && (state_q == ST_DUMMY
               || state_q == ST_DATA)) begin
            cont_q <= cont_next_q;
         end else if (cs_rise && state_q == ST_ADDR && cont_q) begin
            cont_q <= 1'b0;
         end
      end
   end

   assign start_data = fall && ((state_q == ST_MODE && latency_code_i == 4'h0
      && mode_cnt_q == (quad_q ? QUAD_MODE_CYCLES : DUAL_MODE_CYCLES))
      || (state_q == ST_DUMMY && dummy_q == 4'h1));
   assign fifo_flush = cs_n_s;

   // Memory fetch, address increments and wraps per byte
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         req_q <= 1'b0;
         mem_addr_o <= ADDR_RESET;
      end else if (enable_i) begin
         if (cs_n_s) begin
            req_q <= 1'b0;
         end else if (state_q == ST_MODE && rise && mode_cnt_q == 4'h0) begin
            mem_addr_o <= addr_bits_q == 6'd24 ? {8'h00, addr_q[23:0]}
               : addr_q;
            req_q <= 1'b1;
         end else if (mem_req_o && mem_ready_i) begin
            mem_addr_o <= mem_addr_o + 32'h1;
         end
      end
   end

   // Bytes fetched but not yet shifted out, capped at buffer depth
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ahead_q <= '0;
      end else if (enable_i) begin
         if (cs_n_s) begin
            ahead_q <= '0;
         end else begin
            ahead_q <= ahead_q + {4'h0, mem_req_o && mem_ready_i}
               - {4'h0, fifo_pop && fifo_valid};
         end
      end
   end
   assign mem_req_o = req_q && (ahead_q < 5'(FIFO_DEPTH));

   read_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .enable_i(enable_i),
      .flush_i(fifo_flush),
      .in_valid_i(mem_valid_i),
      .in_ready_o(),
      .in_data_i(mem_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data)
   );

   // Pop a byte whenever a new byte is loaded into the shifter
   assign fifo_pop = fall && ((start_data) || (state_q == ST_DATA
      && out_cnt_q == nib_last));

   // Output shifter, changes on falling edges
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         shift_q <= '0;
         out_cnt_q <= '0;
         io_o <= '0;
         io_oe_n_o <= 4'hf;
         underrun_o <= 1'b0;
      end else if (enable_i) begin
         if (cs_n_s) begin
            io_oe_n_o <= 4'hf;
            out_cnt_q <= '0;
         end else if (fall && (start_data || (state_q == ST_DATA
               && out_cnt_q == nib_last))) begin
            underrun_o <= !fifo_valid;
            out_cnt_q <= '0;
            io_oe_n_o <= quad_q ? 4'h0 : 4'hc;
            if (quad_q) begin
               io_o <= fifo_data[7:4];
               shift_q <= {fifo_data[3:0], 4'h0};
            end else begin
               io_o <= {2'b00, fifo_data[7:6]};
               shift_q <= {fifo_data[5:0], 2'b00};
            end
         end else if (fall && state_q == ST_DATA) begin
            out_cnt_q <= out_cnt_q + 3'h1;
            if (quad_q) begin
               io_o <= shift_q[7:4];
               shift_q <= {shift_q[3:0], 4'h0};
            end else begin
               io_o <= {2'b00, shift_q[7:6]};
               shift_q <= {shift_q[5:0], 2'b00};
            end
         end
      end
   end

   // Status outputs
   assign execute_in_place_o = cont_q;
   assign busy_o = (state_q != ST_IDLE);
endmodule // multi_io_flash_read
`default_nettype wire

// ==== hw/flash_read_pkg.sv ====
package flash_read_pkg;
   // Instruction codes
   localparam logic [7:0] DUAL_READ_OP = 8'hbb;
   localparam logic [7:0] DUAL_READ_LONG_OP = 8'hbc;
   localparam logic [7:0] QUAD_READ_OP = 8'heb;
   localparam logic [7:0] QUAD_READ_LONG_OP = 8'hec;
   localparam logic [7:0] MODE_RESET_OP = 8'hff;
   // Mode nibble that keeps continuous read alive
   localparam logic [3:0] CONT_MODE_NIBBLE = 4'ha;
   // Address widths in bits
   localparam int SHORT_ADDR_BITS = 24;
   localparam int LONG_ADDR_BITS = 32;
   localparam int ADDR_W = 32;
   // Mode byte cycles per width
   localparam logic [3:0] DUAL_MODE_CYCLES = 4'h4;
   localparam logic [3:0] QUAD_MODE_CYCLES = 4'h2;
   // Data FIFO shape
   localparam int FIFO_W = 8;
   localparam int FIFO_DEPTH = 16;
   // Link clock limit, host side
   localparam int LINK_MAX_MHZ = 133;
   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
endpackage : flash_read_pkg

// ==== hw/read_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module read_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic enable_i,
   input wire logic flush_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;
   logic push;
   logic pop;

   // Status flags
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign empty = (wr_q == rd_q);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign push = in_valid_i && !full;
   assign pop = out_ready_i && !empty;
   assign out_data_o = mem_q[rd_q[AW-1:0]];

   // Storage
   always_ff @(posedge clock_i) begin
      if (enable_i && push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end

   // Pointers
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (enable_i) begin
         if (flush_i) begin
            wr_q <= '0;
            rd_q <= '0;
         end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule // read_fifo
`default_nettype wire

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic enable_i,
   // Raw pins and synchronised copy
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   // Two-stage synchroniser
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else if (enable_i) begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule // pin_sync
`default_nettype wire

// ==== dv/multi_io_flash_read_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module multi_io_flash_read_properties
   import flash_read_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // Link and configuration
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic quad_enable_i,
   input wire logic [3:0] io_o,
   input wire logic [3:0] io_oe_n_o,
   // Memory side and status
   input wire logic mem_req_o,
   input wire logic [ADDR_W-1:0] mem_addr_o,
   input wire logic mem_ready_i,
   input wire logic execute_in_place_o,
   input wire logic busy_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   // Chip select seen high long enough to cross the synchroniser
   sequence cs_parked;
      cs_n_i [*6];
   endsequence
   // Fetch accepted and request still standing
   sequence fetch_on;
      (mem_req_o && mem_ready_i) ##1 mem_req_o;
   endsequence

   // Outputs quiet right after reset
   a_reset_quiet: assert property (disable iff (1'b0) reset_i |=>
      io_oe_n_o == 4'hf && !busy_o && !mem_req_o && !execute_in_place_o)
      else $error("outputs not quiet after reset");
   // Frame end releases the lines and the engine
   a_idle_release: assert property (cs_parked |-> io_oe_n_o == 4'hf)
      else $error("lines driven with chip select high");
   a_idle_quiet: assert property (cs_parked |-> !busy_o)
      else $error("busy with chip select high");
   // Only dual or quad drive patterns
   a_oe_shape: assert property (io_oe_n_o inside {4'hf, 4'hc, 4'h0})
      else $error("illegal drive pattern");
   a_quad_gate: assert property (io_oe_n_o == 4'h0 |-> quad_enable_i)
      else $error("quad drive without quad enable");
   // Address steps by one per accepted fetch, wrapping
   a_addr_step: assert property (fetch_on |->
      mem_addr_o == $past(mem_addr_o) + 32'h1)
      else $error("fetch address did not step");
   // Data changes only after a link falling edge
   a_io_after_fall: assert property ($changed(io_o) && io_oe_n_o != 4'hf
      |-> !$past(sck_i, 2))
      else $error("data changed outside falling edge");
   a_fetch_start: assert property ($rose(mem_req_o) |-> !cs_n_i && busy_o)
      else $error("fetch outside a frame");
endmodule // multi_io_flash_read_properties

bind multi_io_flash_read multi_io_flash_read_properties u_props (
   .clock_i(clock_i), .reset_i(reset_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
   .quad_enable_i(quad_enable_i), .io_o(io_o), .io_oe_n_o(io_oe_n_o),
   .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
   .mem_ready_i(mem_ready_i), .execute_in_place_o(execute_in_place_o),
   .busy_o(busy_o));
`default_nettype wire

// ==== dv/spi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Link pins toward the device
   output logic sck_o,
   output logic cs_n_o,
   output logic [3:0] line_o,
   // Device drive of the shared lines
   input wire logic [3:0] dev_io_i,
   input wire logic [3:0] dev_oe_n_i
);
   localparam int HALF = 40;
   logic [3:0] drv;
   logic [3:0] hoe_n;
   logic [7:0] rx [0:31];

   // Wire level; a line released by both sides shows the inverse of the host's last drive
   assign line_o = (~dev_oe_n_i & dev_io_i) | (dev_oe_n_i & ~hoe_n & drv)
      | (dev_oe_n_i & hoe_n & ~drv);
   // Link idles with clock still and chip select high
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      drv = 4'h0;
      hoe_n = 4'hf;
   end

   // One full link clock
   task automatic tick();
      #HALF sck_o = 1'b1;
      #HALF sck_o = 1'b0;
   endtask
   // Send n bits top first, w bits per rising edge
   task automatic shift(input logic [31:0] v, input int w, input int n);
      logic [31:0] s;
      s = v << (32 - n);
      hoe_n = (w == 4) ? 4'h0 : (w == 2) ? 4'hc : 4'he;
      repeat (n / w) begin
         drv = 4'(s >> (32 - w));
         s = s << w;
         tick();
      end
   endtask
   task automatic start();
      cs_n_o = 1'b0;
      #HALF;
   endtask
   task automatic stop();
      #HALF cs_n_o = 1'b1;
      hoe_n = 4'hf;
      #(10 * HALF);
   endtask
   // Whole read frame, chip select low throughout
   task automatic frame(input bit ins, input bit qi, input logic [7:0] op,
      input int w, input int ab, input logic [31:0] a, input logic [7:0] m,
      input int lc, input int nb);
      start();
      if (ins) shift({24'h0, op}, qi ? 4 : 1, 8);
      shift(a, w, ab);
      shift({28'h0, m[7:4]}, w, 4);
      hoe_n = 4'hf;
      repeat (4 / w) tick();
      repeat (lc) tick();
      for (int k = 0; k < nb; k++) begin
         rx[k] = 8'h0;
         repeat (8 / w) begin
            #HALF sck_o = 1'b1;
            #(HALF - 1);
            rx[k] = 8'((rx[k] << w) | (line_o & ((w == 4) ? 4'hf : 4'h3)));
            #1 sck_o = 1'b0;
         end
      end
      stop();
   endtask
endmodule // spi_host_model
`default_nettype wire

// ==== dv/multi_io_flash_read_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
   bad_count++; $display("[ERR] %s expected %h seen %h", nm, ex, got); \
   end end
module multi_io_flash_read_bench
   import flash_read_pkg::*;
;
   logic clock_i, reset_i, sck, cs_n, addr_long, qe, qim, drove;
   logic [3:0] line, io_o, io_oe_n, lat;
   logic mem_req, mem_ready, mem_valid, execute_in_place, busy, underrun, acc;
   logic [ADDR_W-1:0] mem_addr, aad;
   logic [7:0] mem_data;
   int bad_count, check_count;

   multi_io_flash_read u_multi_io_flash_read (
      .clock_i(clock_i), .reset_i(reset_i), .enable_i(1'b1), .sck_i(sck),
      .cs_n_i(cs_n), .io_i(line), .io_o(io_o), .io_oe_n_o(io_oe_n),
      .addr_long_i(addr_long), .quad_enable_i(qe),
      .quad_instruction_mode_i(qim), .latency_code_i(lat),
      .mem_req_o(mem_req), .mem_addr_o(mem_addr), .mem_ready_i(mem_ready),
      .mem_valid_i(mem_valid), .mem_data_i(mem_data),
      .execute_in_place_o(execute_in_place), .busy_o(busy), .underrun_o(underrun));
   spi_host_model u_spi_host_model (.sck_o(sck), .cs_n_o(cs_n),
      .line_o(line), .dev_io_i(io_o), .dev_oe_n_i(io_oe_n));

   // Memory contents as a function of the byte address
   function automatic logic [7:0] mem_byte(input logic [31:0] x);
      return x[7:0] ^ {1'b0, x[31:25]} ^ 8'h3c;
   endfunction
   // Clock
   always #5 clock_i = ~clock_i;
   // Memory: take accepted fetches, answer and stall on alternate cycles
   always @(posedge clock_i) begin
      acc <= mem_req & mem_ready;
      aad <= mem_addr;
      if (io_oe_n !== 4'hf) drove <= 1'b1;
   end
   always @(negedge clock_i) begin
      mem_valid <= acc;
      mem_data <= mem_byte(aad);
      mem_ready <= ~mem_ready;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic idle_wait();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         @(negedge clock_i);
         n++;
      end
      if (n >= 100) begin
         bad_count++;
         $display("[ERR] busy expected 0 seen %b", busy);
         test_done();
      end
   endtask
   // One read frame, then data, status and mode checks
   task automatic rd(input bit ins, input bit qi, input logic [7:0] op,
      input int w, input int ab, input logic [31:0] a, input logic [7:0] m,
      input int lc, input int nb, input logic xp);
      @(negedge clock_i) lat = 4'(lc);
      u_spi_host_model.frame(ins, qi, op, w, ab, a, m, lc, nb);
      idle_wait();
      for (int k = 0; k < nb; k++)
         `CHK("read byte", mem_byte(a + 32'(k)), u_spi_host_model.rx[k])
      `CHK("underrun", 1'b0, underrun)
      `CHK("continuous", xp, execute_in_place)
   endtask

   // Main sequence
   initial begin
      {clock_i, addr_long, qe, qim, drove, mem_ready, acc, mem_valid} = '0;
      {lat, aad, mem_data} = '0;
      reset_i = 1'b1;
      repeat (5) @(negedge clock_i);
      reset_i = 1'b0;
      repeat (3) @(negedge clock_i);
      `CHK("idle drive", 4'hf, io_oe_n)
      rd(1, 0, DUAL_READ_OP, 2, 24, 32'h0012_3456, 8'ha5, 0, 3, 1);
      rd(0, 0, 8'h00, 2, 24, 32'h0000_00fe, 8'h5f, 1, 3, 0);
      @(negedge clock_i) addr_long = 1'b1;
      rd(1, 0, DUAL_READ_OP, 2, 32, 32'h8000_0001, 8'h00, 2, 2, 0);
      @(negedge clock_i) addr_long = 1'b0;
      rd(1, 0, DUAL_READ_LONG_OP, 2, 32, 32'hffff_fffe, 8'h00, 3, 4, 0);
      drove = 1'b0;
      rd(1, 0, QUAD_READ_OP, 4, 24, 32'h0000_0100, 8'h00, 0, 0, 0);
      `CHK("refused drive", 1'b0, drove)
      @(negedge clock_i) qe = 1'b1;
      rd(1, 0, QUAD_READ_LONG_OP, 4, 32, 32'h0100_00ff, 8'ha0, 4, 4, 1);
      rd(0, 0, 8'h00, 4, 32, 32'h0000_1000, 8'hf0, 0, 2, 0);
      rd(1, 0, QUAD_READ_OP, 4, 24, 32'h00ab_cdef, 8'ha3, 2, 1, 1);
      u_spi_host_model.start();
      u_spi_host_model.shift(32'hffff_ffff, 4, 32);
      u_spi_host_model.stop();
      idle_wait();
      `CHK("mode reset", 1'b0, execute_in_place)
      @(negedge clock_i) qim = 1'b1;
      rd(1, 1, QUAD_READ_OP, 4, 24, 32'h0000_0040, 8'h00, 1, 2, 0);
      // Read longer than the buffer, fetches must stall without loss
      @(negedge clock_i) qim = 1'b0;
      rd(1, 0, DUAL_READ_OP, 2, 24, 32'h0000_3000, 8'ha0, 1, 20, 1);
      // Reset in mid-run drops continuous mode and idles the link side
      @(negedge clock_i) reset_i = 1'b1;
      repeat (2) @(negedge clock_i);
      reset_i = 1'b0;
      repeat (3) @(negedge clock_i);
      `CHK("reset mode", 1'b0, execute_in_place)
      `CHK("reset drive", 4'hf, io_oe_n)
      `CHK("reset fetch", 1'b0, mem_req)
      test_done();
   end
endmodule // multi_io_flash_read_bench
`default_nettype wire
